// *** rtl/arcs_seq.sv ***
// arcs_seq: three-pole single and multi shot reclose sequencer
// assumes all inputs synchronous to clk_sys, settings static while in use
`timescale 1ns/1ns
module arcs_seq #(
    // system clocks per timer tick
    parameter int TICK_DIV = arcs_pkg::TICK_DIV
) (
    // clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    // protection elements and external inputs
    input  wire arcs_pkg::arcs_prot_s         prot,
    input  wire logic                         ext_pickup,
    input  wire logic                         ground_program_start_input,
    input  wire logic                         phase_program_start_input,
    input  wire logic                         dead_time_hold_input,
    input  wire logic                         block_input,
    // breaker
    input  wire logic                         aux_used,
    input  wire logic                         breaker_closed_aux,
    output logic                              close_cmd,
    // settings
    input  wire logic [2*arcs_pkg::NSRC-1:0]  src_cfg,
    input  wire arcs_pkg::arcs_prog_s         gnd_prog,
    input  wire arcs_pkg::arcs_prog_s         ph_prog,
    input  wire arcs_pkg::arcs_time_s         times,
    // status
    output logic                              dynamic_lockout_flag,
    output logic                              hold_timeout_flag,
    output logic                              ground_program_active,
    output logic [3:0]                        shot_count,
    output logic [15:0]                       first_shot_closes,
    output logic [15:0]                       later_shot_closes,
    output arcs_pkg::arcs_state_e             state
);
    arcs_pkg::arcs_state_e   st_q;
    logic [31:0]             div_q;
    logic                    tick;
    logic [arcs_pkg::NSRC-1:0] is_start;
    logic [arcs_pkg::NSRC-1:0] is_block;
    logic                    st_pu;
    logic                    st_trip;
    logic                    blk_trip;
    logic                    gen_pu;
    logic                    any_trip;
    logic                    brk_open;
    logic [2:0]              ph_acc_q;
    logic                    gnd_acc_q;
    logic                    gnd_force_q;
    logic                    ph_force_q;
    logic                    gnd_sel_q;
    logic [3:0]              shot_q;
    logic [3:0]              shot_lim;
    logic [arcs_pkg::TW-1:0] dead_dur;
    logic                    close_q;
    logic                    dyn_q;
    logic                    hto_q;
    logic                    restr_pend_q;
    logic [15:0]             first_q;
    logic [15:0]             later_q;
    logic                    act_ld;
    logic                    hold_ld;
    logic                    dead_ld;
    logic                    restr_ld;
    logic                    lock_ld;
    logic                    cl_ld;
    logic                    act_run;
    logic                    act_exp;
    logic                    hold_exp;
    logic                    dead_exp;
    logic                    restr_run;
    logic                    restr_exp;
    logic                    cl_run;
    logic                    cl_exp;
    logic                    lock_exp;
    logic                    blk_cond;
    logic                    enter_lock;

    // decode a two-bit source setting
    function automatic logic cfg_is(input logic [1:0] c, input logic [1:0] want);
        cfg_is = (c == want);
    endfunction

    // per-source role decode
    genvar gi;
    generate
        for (gi = 0; gi < arcs_pkg::NSRC; gi++) begin : g_src
            assign is_start[gi] = cfg_is(src_cfg[2*gi +: 2], arcs_pkg::CFG_START);
            assign is_block[gi] = cfg_is(src_cfg[2*gi +: 2], arcs_pkg::CFG_BLOCK);
        end
    endgenerate

    // starter pickup, including the external relay pickup input
    assign st_pu    = |(prot.pickup & is_start) | ext_pickup;
    assign st_trip  = |(prot.trip & is_start);
    assign blk_trip = |(prot.trip & is_block);
    assign gen_pu   = |prot.pickup | ext_pickup;
    assign any_trip = |prot.trip;
    // breaker open from aux contact, else pickup dropout
    assign brk_open = aux_used ? !breaker_closed_aux : !gen_pu;

    // millisecond tick from the system clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_q <= '0;
        end else if (div_q == 32'(TICK_DIV - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 32'h1;
        end
    end
    assign tick = (div_q == 32'(TICK_DIV - 1));

    // active program settings, dead times 5+ reuse the fourth
    always_comb begin
        arcs_pkg::arcs_prog_s p;
        logic [1:0] idx;
        p   = gnd_sel_q ? gnd_prog : ph_prog;
        idx = (shot_q >= 4'h3) ? 2'h3 : shot_q[1:0];
        shot_lim = (p.shots > 4'(arcs_pkg::SHOT_MAX)) ? 4'(arcs_pkg::SHOT_MAX) : p.shots;
        dead_dur = p.dead[idx*arcs_pkg::TW +: arcs_pkg::TW];
    end

    // timers
    arcs_timer u_act (.clk_sys(clk_sys), .rst(rst), .tick(tick), .load(act_ld),
        .stop(st_q != arcs_pkg::ST_ACT), .dur(times.action), .running(act_run),
        .expired(act_exp));
    arcs_timer u_hold (.clk_sys(clk_sys), .rst(rst), .tick(tick), .load(hold_ld),
        .stop(st_q != arcs_pkg::ST_HOLD), .dur(times.hold_mon), .running(),
        .expired(hold_exp));
    arcs_timer u_dead (.clk_sys(clk_sys), .rst(rst), .tick(tick), .load(dead_ld),
        .stop(st_q != arcs_pkg::ST_DEAD), .dur(dead_dur), .running(),
        .expired(dead_exp));
    arcs_timer u_restr (.clk_sys(clk_sys), .rst(rst), .tick(tick), .load(restr_ld),
        .stop(st_q != arcs_pkg::ST_RESTR), .dur(times.restraint), .running(restr_run),
        .expired(restr_exp));
    arcs_timer u_close (.clk_sys(clk_sys), .rst(rst), .tick(tick), .load(cl_ld),
        .stop(any_trip), .dur(times.close_max), .running(cl_run),
        .expired(cl_exp));
    arcs_timer u_lock (.clk_sys(clk_sys), .rst(rst), .tick(tick), .load(lock_ld),
        .stop(1'b0), .dur(times.lockout), .running(),
        .expired(lock_exp));

    // timer starts
    assign act_ld  = (st_q == arcs_pkg::ST_IDLE) && st_pu;
    // hold monitor is re-armed by a retrip during restraint as well
    assign hold_ld = ((st_q == arcs_pkg::ST_ACT) && act_run && st_trip)
                   || ((st_q == arcs_pkg::ST_RESTR) && st_trip);
    assign dead_ld = ((st_q == arcs_pkg::ST_HOLD) && !dead_time_hold_input && brk_open)
                   || ((st_q == arcs_pkg::ST_OPEN) && brk_open);
    // restraint starts with close, and is re-armed by starter pickup
    assign restr_ld = ((st_q == arcs_pkg::ST_DEAD) && dead_exp)
                    || ((st_q == arcs_pkg::ST_RESTR) && st_pu && !st_trip
                        && !restr_pend_q);
    assign cl_ld   = (st_q == arcs_pkg::ST_DEAD) && dead_exp;
    assign blk_cond = block_input || blk_trip;
    assign lock_ld = enter_lock || ((st_q == arcs_pkg::ST_LOCK) && lock_exp && blk_cond);

    // conditions that drive the sequencer into dynamic blocking
    always_comb begin
        enter_lock = 1'b0;
        if (st_q != arcs_pkg::ST_LOCK && st_q != arcs_pkg::ST_IDLE && blk_cond) begin
            enter_lock = 1'b1;
        end else if (st_q == arcs_pkg::ST_IDLE && blk_trip) begin
            enter_lock = 1'b1;
        end else if (st_q == arcs_pkg::ST_ACT && !act_run && st_trip) begin
            enter_lock = 1'b1;
        end else if (st_q == arcs_pkg::ST_HOLD && hold_exp && dead_time_hold_input) begin
            enter_lock = 1'b1;
        end else if (st_q == arcs_pkg::ST_RESTR && st_trip && shot_q >= shot_lim) begin
            enter_lock = 1'b1;
        end
    end

    // sequencer state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= arcs_pkg::ST_IDLE;
        end else if (enter_lock) begin
            st_q <= arcs_pkg::ST_LOCK;
        end else begin
            case (st_q)
                arcs_pkg::ST_IDLE: begin
                    if (st_pu) begin
                        st_q <= arcs_pkg::ST_ACT;
                    end
                end
                arcs_pkg::ST_ACT: begin
                    if (act_run && st_trip) begin
                        st_q <= arcs_pkg::ST_HOLD;
                    end else if (!act_run && !gen_pu) begin
                        st_q <= arcs_pkg::ST_IDLE;
                    end
                end
                arcs_pkg::ST_HOLD: begin
                    if (!dead_time_hold_input) begin
                        st_q <= brk_open ? arcs_pkg::ST_DEAD : arcs_pkg::ST_OPEN;
                    end
                end
                arcs_pkg::ST_OPEN: begin
                    if (brk_open) begin
                        st_q <= arcs_pkg::ST_DEAD;
                    end
                end
                arcs_pkg::ST_DEAD: begin
                    if (dead_exp) begin
                        st_q <= arcs_pkg::ST_RESTR;
                    end
                end
                arcs_pkg::ST_RESTR: begin
                    if (st_trip) begin
                        st_q <= arcs_pkg::ST_HOLD;
                    end else if (!restr_run && !restr_pend_q && !cl_run) begin
                        st_q <= arcs_pkg::ST_IDLE;
                    end
                end
                arcs_pkg::ST_LOCK: begin
                    if (lock_exp && !blk_cond) begin
                        st_q <= arcs_pkg::ST_IDLE;
                    end
                end
                default: st_q <= arcs_pkg::ST_IDLE;
            endcase
        end
    end

    // restraint expired but close pulse still running: wait for it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            restr_pend_q <= 1'b0;
        end else if (st_q != arcs_pkg::ST_RESTR) begin
            restr_pend_q <= 1'b0;
        end else if (restr_exp && cl_run) begin
            restr_pend_q <= 1'b1;
        end else if (!cl_run) begin
            restr_pend_q <= 1'b0;
        end
    end

    // fault type accumulation, pickups only, frozen from dead time start until a retrip in restraint
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ph_acc_q    <= '0;
            gnd_acc_q   <= 1'b0;
            gnd_force_q <= 1'b0;
            ph_force_q  <= 1'b0;
        end else if (st_q == arcs_pkg::ST_IDLE) begin
            ph_acc_q    <= prot.phase_pu;
            gnd_acc_q   <= prot.ground_pu;
            gnd_force_q <= ground_program_start_input;
            ph_force_q  <= phase_program_start_input;
        end else if (st_q == arcs_pkg::ST_ACT || st_q == arcs_pkg::ST_HOLD
                     || (st_q == arcs_pkg::ST_OPEN && !brk_open)) begin
            ph_acc_q    <= ph_acc_q | prot.phase_pu;
            gnd_acc_q   <= gnd_acc_q | prot.ground_pu;
            gnd_force_q <= gnd_force_q | ground_program_start_input;
            ph_force_q  <= ph_force_q | phase_program_start_input;
        end
    end

    // program choice: at most one phase means ground program
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gnd_sel_q <= 1'b0;
        end else if (hold_ld) begin
            if (ph_force_q) begin
                gnd_sel_q <= 1'b0;
            end else if (gnd_force_q) begin
                gnd_sel_q <= 1'b1;
            end else begin
                gnd_sel_q <= ($countones(ph_acc_q | prot.phase_pu) <= 1);
            end
        end
    end

    // shot counter: advances on each close, clears when idle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            shot_q <= '0;
        end else if (st_q == arcs_pkg::ST_IDLE) begin
            shot_q <= '0;
        end else if (cl_ld) begin
            shot_q <= shot_q + arcs_pkg::SHOT_ONE;
        end
    end

    // close command, withdrawn on any new trip
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            close_q <= 1'b0;
        end else if (cl_ld && shot_q < shot_lim && !enter_lock) begin
            close_q <= 1'b1;
        end else if (any_trip || cl_exp || !cl_run) begin
            close_q <= 1'b0;
        end
    end

    // close statistics
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            first_q <= '0;
            later_q <= '0;
        end else if (cl_ld && shot_q == 4'h0) begin
            first_q <= first_q + arcs_pkg::CNT_ONE;
        end else if (cl_ld) begin
            later_q <= later_q + arcs_pkg::CNT_ONE;
        end
    end

    // lockout flags, hold timeout flag kept until lockout ends
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dyn_q <= 1'b0;
            hto_q <= 1'b0;
        end else if (enter_lock) begin
            dyn_q <= 1'b1;
            hto_q <= (st_q == arcs_pkg::ST_HOLD) && hold_exp && dead_time_hold_input;
        end else if (st_q == arcs_pkg::ST_LOCK && lock_exp && !blk_cond) begin
            dyn_q <= 1'b0;
            hto_q <= 1'b0;
        end
    end

    assign close_cmd             = close_q;
    assign dynamic_lockout_flag  = dyn_q;
    assign hold_timeout_flag     = hto_q;
    assign ground_program_active = gnd_sel_q;
    assign shot_count            = shot_q;
    assign first_shot_closes     = first_q;
    assign later_shot_closes     = later_q;
    assign state                 = st_q;

    // checks
    property p_close_cut;
        @(posedge clk_sys) disable iff (rst) close_q && any_trip |=> !close_q;
    endproperty
    a_close_cut: assert property (p_close_cut) else $error("close not cut by trip");

    property p_close_restr;
        @(posedge clk_sys) disable iff (rst) $rose(close_q) |-> st_q == arcs_pkg::ST_RESTR;
    endproperty
    a_close_restr: assert property (p_close_restr) else $error("close outside restraint");

    property p_hold_lock;
        @(posedge clk_sys) disable iff (rst)
            st_q == arcs_pkg::ST_HOLD && hold_exp && dead_time_hold_input
            |=> dyn_q && hto_q && st_q == arcs_pkg::ST_LOCK;
    endproperty
    a_hold_lock: assert property (p_hold_lock) else $error("hold timeout not locked");

    property p_hold_wait;
        @(posedge clk_sys) disable iff (rst)
            st_q == arcs_pkg::ST_HOLD && dead_time_hold_input |=> st_q != arcs_pkg::ST_DEAD;
    endproperty
    a_hold_wait: assert property (p_hold_wait) else $error("dead time began during hold");

    property p_late_trip;
        @(posedge clk_sys) disable iff (rst)
            st_q == arcs_pkg::ST_ACT && !act_run && st_trip |=> st_q == arcs_pkg::ST_LOCK;
    endproperty
    a_late_trip: assert property (p_late_trip) else $error("late trip not locked");

    property p_first_cnt;
        @(posedge clk_sys) disable iff (rst)
            cl_ld && shot_q == 4'h0 |=> first_q == $past(first_q) + 16'h0001;
    endproperty
    a_first_cnt: assert property (p_first_cnt) else $error("first close not counted");

    property p_shot_lim;
        @(posedge clk_sys) disable iff (rst) close_q |-> shot_q <= 4'h9;
    endproperty
    a_shot_lim: assert property (p_shot_lim) else $error("shot beyond nine");

    property p_last_fault;
        @(posedge clk_sys) disable iff (rst)
            st_q == arcs_pkg::ST_RESTR && st_trip && shot_q >= shot_lim |=> dyn_q;
    endproperty
    a_last_fault: assert property (p_last_fault) else $error("final trip not locked");
endmodule

// *** rtl/arcs_pkg.sv ***
// arcs_pkg: constants, states and carrier types of the auto reclose sequencer
// assumes a 100 MHz system clock and millisecond timer ticks
package arcs_pkg;
    localparam int CLK_MHZ   = 100;
    localparam int TICK_US   = 1000;
    localparam int TICK_DIV  = CLK_MHZ * TICK_US;
    localparam int NSRC      = 12;
    localparam int TW        = 16;
    localparam int SHOT_MAX  = 9;
    localparam int NDEAD     = 4;
    localparam logic [1:0] CFG_NONE  = 2'h0;
    localparam logic [1:0] CFG_START = 2'h1;
    localparam logic [1:0] CFG_BLOCK = 2'h2;
    localparam logic [3:0] SHOT_ONE  = 4'h1;
    localparam logic [15:0] CNT_ONE  = 16'h0001;

    // one-hot sequencer states
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ACT   = 7'h02,
        ST_HOLD  = 7'h04,
        ST_OPEN  = 7'h08,
        ST_DEAD  = 7'h10,
        ST_RESTR = 7'h20,
        ST_LOCK  = 7'h40
    } arcs_state_e;

    // per-source pickup and trip events with per-phase information
    typedef struct packed {
        logic [NSRC-1:0] pickup;
        logic [NSRC-1:0] trip;
        logic [2:0]      phase_pu;
        logic            ground_pu;
    } arcs_prot_s;

    // shot count and dead time durations in ticks for one program
    typedef struct packed {
        logic [3:0]           shots;
        logic [NDEAD*TW-1:0]  dead;
    } arcs_prog_s;

    // common timer settings in ticks
    typedef struct packed {
        logic [TW-1:0] action;
        logic [TW-1:0] hold_mon;
        logic [TW-1:0] restraint;
        logic [TW-1:0] close_max;
        logic [TW-1:0] lockout;
    } arcs_time_s;
endpackage

// *** rtl/arcs_timer.sv ***
// arcs_timer: loadable down counter stepped by the common tick
// assumes load and tick are synchronous one-cycle strobes
`timescale 1ns/1ns
module arcs_timer (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // control
    input  wire logic                  tick,
    input  wire logic                  load,
    input  wire logic                  stop,
    input  wire logic [arcs_pkg::TW-1:0] dur,
    // status
    output logic                       running,
    output logic                       expired
);
    logic [arcs_pkg::TW-1:0] cnt_q;
    logic                    run_q;

    // duration latched at start, counts ticks down
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (load) begin
            cnt_q <= dur;
            run_q <= 1'b1;
        end else if (stop) begin
            run_q <= 1'b0;
        end else if (run_q && tick) begin
            if (cnt_q <= 16'h0001) begin
                run_q <= 1'b0;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q - 16'h0001;
            end
        end
    end

    assign running = run_q;
    assign expired = run_q && tick && (cnt_q <= 16'h0001) && !load && !stop;
endmodule

// *** tb/arcs_tb_brk.sv ***
// arcs_tb_brk: breaker model, opens on any trip, closes on close command
// assumes trip and close are levels synchronous to clk_sys
`timescale 1ns/1ns
module arcs_tb_brk (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // commands
    input  wire logic trip,
    input  wire logic close_cmd,
    // aux contact, high while closed
    output logic      breaker_closed_aux
);
    logic       pos_q;
    logic [2:0] mech_q;
    // position latches the last command, trip wins; contact trails it like a slow mechanism
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pos_q              <= 1'b1;
            mech_q             <= 3'h7;
            breaker_closed_aux <= 1'b1;
        end else begin
            pos_q              <= trip ? 1'b0 : (close_cmd | pos_q);
            mech_q             <= {mech_q[1:0], pos_q};
            breaker_closed_aux <= mech_q[2];
        end
    end
endmodule

// *** tb/tb_top.sv ***
// tb_top: self-checking bench of the reclose sequencer
// runs the tick divider at ten clocks so that every timer takes few cycles
`timescale 1ns/1ns
module tb_top;
    logic                  clk_sys = 1'b0;
    logic                  rst = 1'b1;
    arcs_pkg::arcs_prot_s  prot = '0;
    logic                  ext_pickup = 1'b0;
    logic                  hold_in = 1'b0;
    logic                  brk_aux, close_cmd, dyn_flag, hto_flag, gpa, cl_d1, cl_d2;
    logic [3:0]            shot_count;
    logic [15:0]           first_cl, later_cl;
    arcs_pkg::arcs_state_e state, st_prev_q;
    logic [23:0]           src_cfg = 24'h000009; // src0 start, src1 block, others none
    arcs_pkg::arcs_prog_s  gnd_prog = {4'h1, 64'h0004_0003_0002_0001};
    arcs_pkg::arcs_prog_s  ph_prog = {4'h2, 64'h0004_0003_0002_0001};
    arcs_pkg::arcs_time_s  times = {16'h0100, 16'h0010, 16'h0008, 16'h000C, 16'h0004};
    logic [8:0]            exp_st[$];
    logic [12:0]           exp_cl[$];
    int                    err_count = 0;
    int                    checked = 0;
    int                    cyc = 0;

    always #5 clk_sys = ~clk_sys;

    arcs_seq #(.TICK_DIV(10)) dut (.clk_sys(clk_sys), .rst(rst), .prot(prot),
        .ext_pickup(ext_pickup),
        .ground_program_start_input(1'b0), .phase_program_start_input(1'b0),
        .dead_time_hold_input(hold_in), .block_input(1'b0), .aux_used(1'b1),
        .breaker_closed_aux(brk_aux), .close_cmd(close_cmd), .src_cfg(src_cfg),
        .gnd_prog(gnd_prog), .ph_prog(ph_prog), .times(times),
        .dynamic_lockout_flag(dyn_flag), .hold_timeout_flag(hto_flag),
        .ground_program_active(gpa), .shot_count(shot_count),
        .first_shot_closes(first_cl), .later_shot_closes(later_cl), .state(state));

    arcs_tb_brk brk (.clk_sys(clk_sys), .rst(rst), .trip(|prot.trip),
        .close_cmd(close_cmd), .breaker_closed_aux(brk_aux));

    // verdict; expectations never seen count as mismatches
    task automatic summarize();
        err_count += exp_st.size() + exp_cl.size();
        $display("checked %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // settled state with lockout flag against the oldest note
    task automatic chk_st(input logic [8:0] got);
        logic [8:0] e;
        e = exp_st.size() ? exp_st.pop_front() : 9'h1FF;
        checked++;
        if (got !== e) begin
            err_count++;
            $display("ERROR state expected %h seen %h", e, got);
        end
    endtask

    // program, shot and counters after a close against the oldest note
    task automatic chk_cl(input logic [12:0] got);
        logic [12:0] e;
        e = exp_cl.size() ? exp_cl.pop_front() : 13'h1FFF;
        checked++;
        if (got !== e) begin
            err_count++;
            $display("ERROR close expected %h seen %h", e, got);
        end
    endtask

    // monitor: results compared as they appear, plus the hang limit
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            summarize();
        end
        if (!rst && state !== st_prev_q
            && !(state inside {arcs_pkg::ST_ACT, arcs_pkg::ST_OPEN, arcs_pkg::ST_DEAD}))
            chk_st({hto_flag, dyn_flag, state});
        if (cl_d1 && !cl_d2)
            chk_cl({gpa, shot_count, first_cl[3:0], later_cl[3:0]});
        st_prev_q = state;
        cl_d2 = cl_d1;
        cl_d1 = !rst && close_cmd;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic ex(input logic f, input logic [6:0] s, input logic h = 1'b0);
        exp_st.push_back({h, f, s});
    endtask

    task automatic wait_st(input logic [6:0] s);
        for (int i = 0; i < 5000 && state !== s; i++) step(1);
    endtask

    // breaker settles, starter pickup, then trip held until the breaker opens
    task automatic fault(input logic [2:0] ph, input logic gd);
        for (int i = 0; i < 20 && !brk_aux; i++) step(1);
        prot.pickup[0] = 1'b1;
        prot.phase_pu = ph;
        prot.ground_pu = gd;
        step(2);
        prot.trip[0] = 1'b1;
        step(1);
        for (int i = 0; i < 20 && brk_aux; i++) step(1);
        prot = '0;
    endtask

    initial begin
        logic [2:0] ph;
        logic       gd;
        void'($urandom(32'h98a3));
        step(3);
        rst = 1'b0;
        // single phase fault, dead time held off, one shot succeeds
        ph = 3'(3'h1 << ($urandom % 3));
        gd = 1'($urandom % 2);
        hold_in = 1'b1;
        ex(1'b0, arcs_pkg::ST_HOLD);
        ex(1'b0, arcs_pkg::ST_RESTR);
        exp_cl.push_back({1'b1, 4'h1, 4'h1, 4'h0});
        ex(1'b0, arcs_pkg::ST_IDLE);
        fault(ph, gd);
        step(50);
        hold_in = 1'b0;
        wait_st(arcs_pkg::ST_IDLE);
        // two phase fault, two shots fail, last retrip locks out
        ph = 3'h7 ^ 3'(3'h1 << ($urandom % 3));
        ex(1'b0, arcs_pkg::ST_HOLD);
        ex(1'b0, arcs_pkg::ST_RESTR);
        exp_cl.push_back({1'b0, 4'h1, 4'h2, 4'h0});
        ex(1'b0, arcs_pkg::ST_HOLD);
        ex(1'b0, arcs_pkg::ST_RESTR);
        exp_cl.push_back({1'b0, 4'h2, 4'h2, 4'h1});
        ex(1'b1, arcs_pkg::ST_LOCK);
        ex(1'b0, arcs_pkg::ST_IDLE);
        fault(ph, gd);
        wait_st(arcs_pkg::ST_RESTR);
        step(8);
        fault(ph, gd);
        wait_st(arcs_pkg::ST_RESTR);
        step(8);
        fault(ph, gd);
        wait_st(arcs_pkg::ST_IDLE);
        // external pickup, then a blocking source trips
        ex(1'b1, arcs_pkg::ST_LOCK);
        ex(1'b0, arcs_pkg::ST_IDLE);
        ext_pickup = 1'b1;
        step(2);
        prot.trip[1] = 1'b1;
        step(5);
        prot = '0;
        ext_pickup = 1'b0;
        wait_st(arcs_pkg::ST_IDLE);
        // dead time held past the hold monitor: lockout with timeout flag
        ex(1'b0, arcs_pkg::ST_HOLD);
        ex(1'b1, arcs_pkg::ST_LOCK, 1'b1);
        ex(1'b0, arcs_pkg::ST_IDLE);
        hold_in = 1'b1;
        fault(ph, gd);
        wait_st(arcs_pkg::ST_IDLE);
        hold_in = 1'b0;
        step(3);
        summarize();
    end
endmodule
